//--- rtl/mdc_top.sv
// Four-descriptor DMA status, address and control registers with mover
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
// Operation
// - Set descriptor 0 done flag on any end
// - Clear done on irq-clear write or arming
// - Four free flags, status bits 3:0, reset one
// - Free flag rises when transfer ends
// - Four 32-bit source address registers, reset zero
// - Four 32-bit destination address registers, reset zero
// - Source address low two bits ignored
// - Destination address low two bits ignored
// - Source address advances per good read
// - Destination address advances per good write
// - Source register shows live position
// - Destination register updated in place
// - Read source, write destination, per descriptor
// - Armed clears on completion; locks fields
// - Direction bit: 0 AHB-to-DDR, 1 reverse
// - 16-bit size, low bits ignored, zero=64K
// - Abort bit terminates, resets, reads zero
module mdc_top #(
  parameter int unsigned NDESC = mdc_pkg::NUM_DESC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Source side
  output logic rd_req,
  output logic [31:0] rd_addr,
  output logic rd_ddr_side,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire logic [31:0] rd_data,
  // Destination side
  output logic wr_req,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  output logic wr_ddr_side,
  input wire logic wr_ack,
  input wire logic wr_err,
  // Interrupt
  output logic irq
);
  initial begin
    if (NDESC != 4) $error("mdc_top serves exactly four descriptors");
  end

  logic [31:0] src_r [4];
  logic [31:0] dst_r [4];
  logic [15:0] size_r [4];
  logic [3:0] dir_r;
  logic [3:0] armed_r;
  logic [3:0] free_r;
  logic done0_r;
  logic [16:0] left_r;
  logic [1:0] cur_r;
  logic active_r;
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  logic rd_req_r, wr_req_r;
  logic [31:0] rd_addr_r, wr_addr_r, wr_data_r;
  logic rd_side_r, wr_side_r;
  logic [31:0] reg_rdata_r;
  logic irq_r;

  logic e_rd_req, e_wr_req, e_src, e_dst, e_done, e_fail, e_busy;
  logic [31:0] e_wdata;
  logic start, abort_cur;
  logic [1:0] pick;
  logic [1:0] cur_nxt;
  logic [3:0] wr_ctrl, wr_src, wr_dst, arm_set, abort_set, ended;
  logic irq_clr_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode per descriptor
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dec
      assign wr_src[g] = reg_wr &&
        reg_addr == 8'(mdc_pkg::OFS_SRC_BASE + 8'(4 * g));
      assign wr_dst[g] = reg_wr &&
        reg_addr == 8'(mdc_pkg::OFS_DST_BASE + 8'(4 * g));
      assign wr_ctrl[g] = reg_wr &&
        reg_addr == 8'(mdc_pkg::OFS_CTRL_BASE + 8'(4 * g));
      assign arm_set[g] = wr_ctrl[g] && !armed_r[g] &&
        reg_wdata[mdc_pkg::CR_ARMED_BIT] && !reg_wdata[mdc_pkg::CR_ABORT_BIT];
      assign abort_set[g] = wr_ctrl[g] && reg_wdata[mdc_pkg::CR_ABORT_BIT];
      assign ended[g] = active_r && e_done && cur_r == 2'(g);
    end
  endgenerate
  assign irq_clr_wr = reg_wr && reg_addr == mdc_pkg::OFS_IRQ_CLEAR;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-priority pick of the next armed descriptor, lowest number wins
  always_comb begin
    pick = 2'b00;
    for (int i = 3; i >= 0; i--) begin
      if (armed_r[i]) pick = 2'(i);
    end
  end
  assign start = !active_r && |armed_r;
  assign abort_cur = active_r && abort_set[cur_r];
  // Look ahead so link outputs point at the new descriptor on its first request
  assign cur_nxt = start ? pick : cur_r;

  mdc_engine u_engine (
    .clock(clock),
    .rst(rst),
    .start(start),
    .abort(abort_cur),
    .words_left(left_r),
    .rd_req(e_rd_req),
    .rd_ack(rd_ack),
    .rd_err(rd_err),
    .rd_data(rd_data),
    .wr_req(e_wr_req),
    .wr_data(e_wdata),
    .wr_ack(wr_ack),
    .wr_err(wr_err),
    .src_step(e_src),
    .dst_step(e_dst),
    .done(e_done),
    .failed(e_fail),
    .busy(e_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Active descriptor and remaining word count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_r <= 1'b0;
      cur_r <= 2'b00;
      left_r <= 17'h0_0000;
    end else if (start) begin
      active_r <= 1'b1;
      cur_r <= pick;
      // Zero size means 64 Kbyte, low bits dropped
      if (size_r[pick][15:2] == 14'h0000)
        left_r <= 17'(mdc_pkg::FULL_SIZE >> 2);
      else
        left_r <= {3'b000, size_r[pick][15:2]};
    end else if (e_done || abort_cur) begin
      active_r <= 1'b0;
    end else if (e_dst) begin
      left_r <= 17'(left_r - 17'h0_0001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor address, size and direction fields
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        src_r[i] <= mdc_pkg::ADDR_RST;
        dst_r[i] <= mdc_pkg::ADDR_RST;
        size_r[i] <= 16'h0000;
      end
      dir_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (abort_set[i]) begin
          size_r[i] <= 16'h0000;
          dir_r[i] <= 1'b0;
        end else if (!armed_r[i]) begin
          if (wr_src[i]) src_r[i] <= reg_wdata & mdc_pkg::WORD_MASK;
          if (wr_dst[i]) dst_r[i] <= reg_wdata & mdc_pkg::WORD_MASK;
          if (wr_ctrl[i]) begin
            size_r[i] <= reg_wdata[mdc_pkg::CR_SIZE_MSB:0];
            dir_r[i] <= reg_wdata[mdc_pkg::CR_DIR_BIT];
          end
        end
      end
      if (e_src) src_r[cur_r] <= 32'(src_r[cur_r] + mdc_pkg::WORD_STEP);
      if (e_dst) dst_r[cur_r] <= 32'(dst_r[cur_r] + mdc_pkg::WORD_STEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Armed, free and done flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_r <= 4'h0;
      free_r <= mdc_pkg::FREE_RST;
      done0_r <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (abort_set[i]) begin
          armed_r[i] <= 1'b0;
          free_r[i] <= 1'b1;
        end else if (ended[i]) begin
          // Armed drops at end; free rises
          armed_r[i] <= 1'b0;
          free_r[i] <= 1'b1;
        end else if (arm_set[i]) begin
          armed_r[i] <= 1'b1;
          free_r[i] <= 1'b0;
        end
      end
      // Done on end wins over clears
      if (ended[0]) done0_r <= 1'b1;
      // Clear by irq-clear write or arming
      else if ((irq_clr_wr && reg_wdata[0]) || arm_set[0] || abort_set[0])
        done0_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status per descriptor, write one to clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_stat_r <= 4'h0;
      irq_mask_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ended[i]) irq_stat_r[i] <= 1'b1;
        else if ((irq_clr_wr && reg_wdata[i]) || arm_set[i])
          irq_stat_r[i] <= 1'b0;
        else if (reg_wr && reg_addr == mdc_pkg::OFS_IRQ_STATUS &&
                 reg_wdata[i])
          irq_stat_r[i] <= 1'b0;
      end
      if (reg_wr && reg_addr == mdc_pkg::OFS_IRQ_MASK)
        irq_mask_r <= reg_wdata[3:0];
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered link outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_addr_r <= 32'h0000_0000;
      wr_addr_r <= 32'h0000_0000;
      rd_side_r <= 1'b0;
      wr_side_r <= 1'b0;
    end else begin
      rd_addr_r <= src_r[cur_nxt];
      wr_addr_r <= dst_r[cur_nxt];
      // Direction picks which side is DDR
      rd_side_r <= dir_r[cur_nxt] == mdc_pkg::DIR_DDR_TO_AHB;
      wr_side_r <= dir_r[cur_nxt] == mdc_pkg::DIR_AHB_TO_DDR;
    end
  end
  // Requests come from the engine state flop, gated only by abort
  assign rd_req = e_rd_req;
  assign wr_req = e_wr_req;
  assign wr_data = e_wdata;
  // Address flops settle two cycles after each beat, before the next request
  assign rd_addr = rd_addr_r;
  assign wr_addr = wr_addr_r;
  assign rd_ddr_side = rd_side_r;
  assign wr_ddr_side = wr_side_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= 32'h0000_0000;
    end else begin
      reg_rdata_r <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          mdc_pkg::OFS_STATUS:
            reg_rdata_r <= {27'h0, done0_r, free_r};
          mdc_pkg::OFS_IRQ_STATUS: reg_rdata_r <= {28'h0, irq_stat_r};
          mdc_pkg::OFS_IRQ_MASK: reg_rdata_r <= {28'h0, irq_mask_r};
          default: begin
            for (int i = 0; i < 4; i++) begin
              if (reg_addr == 8'(mdc_pkg::OFS_SRC_BASE + 8'(4 * i)))
                reg_rdata_r <= src_r[i];
              if (reg_addr == 8'(mdc_pkg::OFS_DST_BASE + 8'(4 * i)))
                reg_rdata_r <= dst_r[i];
              // Abort bit always reads zero
              if (reg_addr == 8'(mdc_pkg::OFS_CTRL_BASE + 8'(4 * i)))
                reg_rdata_r <= {14'h0, dir_r[i], armed_r[i], size_r[i]};
            end
          end
        endcase
      end
    end
  end
  assign reg_rdata = reg_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_DONE_SET: assert property (@(posedge clock) disable iff (rst)
    ended[0] |=> done0_r)
    else $error("done flag not set at end");
  AST_DONE_CLR: assert property (@(posedge clock) disable iff (rst)
    (arm_set[0] && !ended[0]) |=> !done0_r)
    else $error("done flag not cleared on arming");
  AST_FREE_END: assert property (@(posedge clock) disable iff (rst)
    |ended |=> free_r[$past(cur_r)])
    else $error("free flag not raised at end");
  AST_FREE_ARM: assert property (@(posedge clock) disable iff (rst)
    (arm_set[1] && !abort_set[1]) |=> !free_r[1] && armed_r[1])
    else $error("free flag not lowered on arming");
  AST_SRC_MASK: assert property (@(posedge clock) disable iff (rst)
    (wr_src[0] && !armed_r[0] && !(e_src && cur_r == 2'b00))
      |=> src_r[0][1:0] == 2'b00)
    else $error("source low bits kept");
  AST_SRC_STEP: assert property (@(posedge clock) disable iff (rst)
    e_src |=> src_r[$past(cur_r)] == 32'($past(rd_addr) + 32'h4))
    else $error("source did not advance by a word");
  AST_DST_STEP: assert property (@(posedge clock) disable iff (rst)
    e_dst |=> dst_r[$past(cur_r)] == 32'($past(wr_addr) + 32'h4))
    else $error("destination did not advance by a word");
  AST_ARMED_LOCK: assert property (@(posedge clock) disable iff (rst)
    (armed_r[2] && wr_src[2] && !(e_src && cur_r == 2'd2))
      |=> $stable(src_r[2]))
    else $error("armed descriptor was overwritten");
  AST_ABORT: assert property (@(posedge clock) disable iff (rst)
    abort_set[3] |=> !armed_r[3] && free_r[3] && size_r[3] == 16'h0)
    else $error("abort did not reset descriptor");
endmodule

//--- rtl/mdc_pkg.sv
// Package: register map, field positions and constants of the DMA descriptor block
package mdc_pkg;
  localparam int unsigned NUM_DESC = 4;
  localparam int unsigned ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_SRC_BASE = 8'h10;
  localparam logic [7:0] OFS_DST_BASE = 8'h20;
  localparam logic [7:0] OFS_CTRL_BASE = 8'h30;
  // Status field positions
  localparam int unsigned ST_FREE_LSB = 0;
  localparam int unsigned ST_DONE0_BIT = 4;
  // Control field positions
  localparam int unsigned CR_SIZE_MSB = 15;
  localparam int unsigned CR_ARMED_BIT = 16;
  localparam int unsigned CR_DIR_BIT = 17;
  localparam int unsigned CR_ABORT_BIT = 18;
  // Reset values, address mask and step, full size
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [3:0] FREE_RST = 4'hF;
  localparam logic [31:0] WORD_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [16:0] FULL_SIZE = 17'h1_0000;
  // Direction encodings
  localparam logic DIR_AHB_TO_DDR = 1'b0;
  localparam logic DIR_DDR_TO_AHB = 1'b1;
  // Transfer engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } mdc_state_type;
endpackage

//--- rtl/mdc_engine.sv
// Single-word mover: reads source, writes destination, reports each beat
`timescale 1ns/1ps
module mdc_engine (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control from descriptor logic
  input wire logic start,
  input wire logic abort,
  input wire logic [16:0] words_left,
  // Source side (read port)
  output logic rd_req,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire logic [31:0] rd_data,
  // Destination side (write port)
  output logic wr_req,
  output logic [31:0] wr_data,
  input wire logic wr_ack,
  input wire logic wr_err,
  // Beat reports
  output logic src_step,
  output logic dst_step,
  output logic done,
  output logic failed,
  output logic busy
);
  mdc_pkg::mdc_state_type state_r;
  logic [31:0] data_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read first, then write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= mdc_pkg::ST_IDLE;
      data_r <= 32'h0000_0000;
    end else if (abort) begin
      state_r <= mdc_pkg::ST_IDLE;
    end else begin
      case (state_r)
        mdc_pkg::ST_IDLE: begin
          if (start) state_r <= mdc_pkg::ST_READ;
        end
        mdc_pkg::ST_READ: begin
          if (rd_ack && rd_err) state_r <= mdc_pkg::ST_IDLE;
          else if (rd_ack) begin
            data_r <= rd_data;
            state_r <= mdc_pkg::ST_WRITE;
          end
        end
        mdc_pkg::ST_WRITE: begin
          if (wr_ack && (wr_err || words_left == 17'h0_0001))
            state_r <= mdc_pkg::ST_IDLE;
          else if (wr_ack) state_r <= mdc_pkg::ST_READ;
        end
        default: state_r <= mdc_pkg::ST_IDLE;
      endcase
    end
  end

  // Combinational beat reports, consumed by the descriptor registers
  assign rd_req = (state_r == mdc_pkg::ST_READ) && !abort;
  assign wr_req = (state_r == mdc_pkg::ST_WRITE) && !abort;
  assign wr_data = data_r;
  assign busy = (state_r != mdc_pkg::ST_IDLE);
  assign src_step = rd_req && rd_ack && !rd_err;
  assign dst_step = wr_req && wr_ack && !wr_err;
  assign failed = (rd_req && rd_ack && rd_err) || (wr_req && wr_ack && wr_err);
  assign done = failed || (dst_step && words_left == 17'h0_0001);

  // Write only follows a good read
  AST_WRITE_AFTER_READ: assert property (@(posedge clock) disable iff (rst)
    $rose(wr_req) |-> $past(src_step))
    else $error("write started without a good read");
endmodule

//--- sim/mdc_partner.sv
// Memory model standing at the mover's source and destination ports
`timescale 1ns/1ps
module mdc_partner (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pacing and fault control from the bench
  input wire logic [7:0] ack_delay,
  input wire logic fail_reads,
  // Source side
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  output logic rd_ack,
  output logic rd_err,
  output logic [31:0] rd_data,
  // Destination side
  input wire logic wr_req,
  input wire logic [31:0] wr_addr,
  input wire logic [31:0] wr_data,
  output logic wr_ack,
  output logic wr_err,
  // Last accepted write
  output logic [31:0] last_waddr,
  output logic [31:0] last_wdata
);
  logic [7:0] rd_wait_r;
  logic [7:0] wr_wait_r;
  ////////////////////////////////////////////////////////////////////////////
  // Read answer; data toggles outside acks so stale words never look valid
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_ack <= 1'b0;
      rd_err <= 1'b0;
      rd_data <= 32'h0000_0000;
      rd_wait_r <= 8'h00;
    end else if (!rd_ack && rd_req && rd_wait_r >= ack_delay) begin
      rd_ack <= 1'b1;
      rd_err <= fail_reads;
      rd_data <= rd_addr ^ 32'hA5A5_0000;
      rd_wait_r <= 8'h00;
    end else begin
      rd_ack <= 1'b0;
      rd_err <= 1'b0;
      rd_data <= ~rd_data;
      rd_wait_r <= (rd_req && !rd_ack) ? rd_wait_r + 8'h01 : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Write answer; the word taken is kept for the bench
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ack <= 1'b0;
      wr_wait_r <= 8'h00;
      last_waddr <= 32'h0000_0000;
      last_wdata <= 32'h0000_0000;
    end else if (!wr_ack && wr_req && wr_wait_r >= ack_delay) begin
      wr_ack <= 1'b1;
      wr_wait_r <= 8'h00;
      last_waddr <= wr_addr;
      last_wdata <= wr_data;
    end else begin
      wr_ack <= 1'b0;
      wr_wait_r <= (wr_req && !wr_ack) ? wr_wait_r + 8'h01 : 8'h00;
    end
  end
  // Writes never fail in this model
  assign wr_err = 1'b0;
endmodule

//--- sim/mdc_top_tb_top.sv
// Register-level bench for the descriptor status and address block
`timescale 1ns/1ps
module mdc_top_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rd_addr, rd_data, wr_addr, wr_data, la, ld, rv;
  logic rd_req, rd_ddr_side, rd_ack, rd_err;
  logic wr_req, wr_ddr_side, wr_ack, wr_err, irq;
  logic [7:0] ack_delay = 8'h14;
  logic fail_reads = 1'b0;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [31:0] SRC0 = 32'h1000_0000;
  localparam logic [31:0] DST0 = 32'h2000_0000;
  localparam logic [31:0] ARM = 32'h0001_0000;
  localparam logic [7:0] ST = mdc_pkg::OFS_STATUS;
  localparam logic [7:0] SA = mdc_pkg::OFS_SRC_BASE;
  localparam logic [7:0] DA = mdc_pkg::OFS_DST_BASE;
  localparam logic [7:0] CA = mdc_pkg::OFS_CTRL_BASE;

  always #5 clock = ~clock;

  mdc_top DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ddr_side(rd_ddr_side), .rd_ack(rd_ack), .rd_err(rd_err),
    .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_ddr_side(wr_ddr_side), .wr_ack(wr_ack),
    .wr_err(wr_err), .irq(irq));

  mdc_partner P (.clock(clock), .rst(rst), .ack_delay(ack_delay),
    .fail_reads(fail_reads), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_ack(wr_ack),
    .wr_err(wr_err), .last_waddr(la), .last_wdata(ld));

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks: one-cycle strobes, read data the cycle after
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(rv, exp);
  endtask
  // Poll status until a free flag returns, bounded
  task automatic wait_free(input int idx);
    for (int k = 0; k < 300; k++) begin
      rd_reg(ST);
      if (rv[idx] === 1'b1) break;
    end
    chk({31'h0, rv[idx]}, 32'h1);
  endtask
  task automatic chk_pins(input logic [31:0] exp);
    for (int k = 0; k < 50 && rd_req !== 1'b1; k++) @(posedge clock);
    #1 chk({30'h0, rd_ddr_side, wr_ddr_side}, exp);
  endtask
  task automatic chk_irq(input logic [31:0] exp);
    repeat (2) @(posedge clock);
    #1 chk({31'h0, irq}, exp);
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    chk_reg(ST, 32'h0000_000F);
    chk_reg(8'hFC, 32'h0000_0000);
    for (int n = 0; n < 4; n++) begin
      chk_reg(SA + 8'(4 * n), 32'h0000_0000);
      chk_reg(DA + 8'(4 * n), 32'h0000_0000);
      wr_reg(SA + 8'(4 * n), SRC0 + 32'(n * 256) + 32'h3);
      wr_reg(DA + 8'(4 * n), DST0 + 32'(n * 256) + 32'h2);
      chk_reg(SA + 8'(4 * n), SRC0 + 32'(n * 256));
      chk_reg(DA + 8'(4 * n), DST0 + 32'(n * 256));
    end
    wr_reg(mdc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    wr_reg(CA, ARM | 32'h0000_0008);
    chk_reg(ST, 32'h0000_000E);
    chk_pins(32'h0000_0001);
    wait_free(0);
    chk_reg(ST, 32'h0000_001F);
    chk_reg(SA, SRC0 + 32'h8);
    chk_reg(DA, DST0 + 32'h8);
    chk(la, DST0 + 32'h4);
    chk(ld, (SRC0 + 32'h4) ^ 32'hA5A5_0000);
    chk_reg(CA, 32'h0000_0008);
    chk_irq(32'h1);
    wr_reg(mdc_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    wr_reg(mdc_pkg::OFS_IRQ_CLEAR, 32'h0000_0001);
    chk_reg(ST, 32'h0000_000F);
    chk_irq(32'h0);
    // failed read ends transfer, reverse direction, masked
    wr_reg(mdc_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    fail_reads <= 1'b1;
    wr_reg(CA, ARM | 32'h0002_0008);
    chk_pins(32'h0000_0002);
    wait_free(0);
    chk_reg(ST, 32'h0000_001F);
    chk_reg(SA, SRC0 + 32'h8);
    chk_irq(32'h0);
    wr_reg(mdc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    chk_irq(32'h1);
    wr_reg(mdc_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    chk_irq(32'h0);
    // arming clears done, locks address, size 6 is one word
    fail_reads <= 1'b0;
    wr_reg(CA, ARM | 32'h0000_0006);
    chk_reg(ST, 32'h0000_000E);
    wr_reg(SA, 32'h5555_5550);
    wait_free(0);
    chk_reg(SA, SRC0 + 32'hC);
    chk_reg(DA, DST0 + 32'hC);
    // abort frees descriptor 1, control reads zero
    wr_reg(CA + 8'h04, ARM | 32'h0000_0008);
    chk_reg(ST, 32'h0000_001D);
    wr_reg(CA + 8'h04, 32'h0004_0000);
    chk_reg(ST, 32'h0000_001F);
    chk_reg(CA + 8'h04, 32'h0000_0000);
    // descriptor 2 armed, source write refused
    wr_reg(CA + 8'h08, ARM | 32'h0000_0004);
    wr_reg(SA + 8'h08, 32'h7777_7770);
    wait_free(2);
    chk_reg(SA + 8'h08, SRC0 + 32'h0000_0204);
    wr_reg(CA + 8'h0C, ARM | 32'h0000_0008);
    wr_reg(CA + 8'h0C, 32'h0004_0000);
    chk_reg(ST, 32'h0000_001F);
    give_verdict();
  end
endmodule
